//--- logic/nvm_seq_pkg.sv
// shared constants and types of the nonvolatile erase/write sequencer
package nvm_seq_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [3:0] IDX_COMMAND  = 4'h0;
  localparam logic [3:0] IDX_MAPPING  = 4'h1;
  localparam logic [3:0] IDX_STATUS   = 4'h2;
  localparam logic [3:0] IDX_INT_EN   = 4'h3;
  localparam logic [3:0] IDX_INT_FLAG = 4'h4;
  localparam logic [3:0] IDX_DATA     = 4'h6;
  localparam logic [3:0] IDX_ADDR     = 4'h8;
  localparam logic [3:0] IDX_UNLOCK   = 4'hc;

  // ****************************************************************
  // command field codes
  // ****************************************************************
  localparam logic [6:0] CMD_NONE       = 7'h00;
  localparam logic [6:0] CMD_NOP        = 7'h01;
  localparam logic [6:0] CMD_FL_WRITE   = 7'h02;
  localparam logic [6:0] CMD_FL_PAGE    = 7'h08;
  localparam logic [6:0] CMD_FL_MP_LO   = 7'h09;
  localparam logic [6:0] CMD_FL_MP_HI   = 7'h0d;
  localparam logic [6:0] CMD_EE_WRITE   = 7'h12;
  localparam logic [6:0] CMD_EE_ERWR    = 7'h13;
  localparam logic [6:0] CMD_EE_BYTE    = 7'h18;
  localparam logic [6:0] CMD_EE_MB_LO   = 7'h19;
  localparam logic [6:0] CMD_EE_MB_HI   = 7'h1d;
  localparam logic [6:0] CMD_CHIP_ERASE = 7'h20;
  localparam logic [6:0] CMD_EE_FULL    = 7'h30;

  // ****************************************************************
  // field layouts, reset values, codes
  // ****************************************************************
  localparam logic [7:0] MAP_RESET    = 8'h30;
  localparam int         MAP_LOCK_BIT = 7;
  localparam logic [7:0] MAP_FLMAP_M  = 8'h30;
  localparam logic [7:0] MAP_PROT_M   = 8'h87;
  localparam logic [2:0] ERR_NONE     = 3'h0;
  localparam logic [2:0] ERR_COLLIDE  = 3'h3;
  localparam logic [2:0] UNLOCK_INSTR = 3'h4;
  localparam logic [15:0] ERASED_DATA = 16'hffff;
  localparam logic [1:0] HTRANS_NSEQ  = 2'b10;

  typedef enum logic [1:0] {
    KEY_NONE = 2'h0,
    KEY_PMS  = 2'h1,
    KEY_IOR  = 2'h2
  } key_kind_t;

  typedef enum logic [3:0] {
    OP_FL_WRITE = 4'h0,
    OP_FL_ERASE = 4'h1,
    OP_EE_WRITE = 4'h2,
    OP_EE_ERWR  = 4'h3,
    OP_EE_ERASE = 4'h4,
    OP_EE_ALL   = 4'h5,
    OP_CHIP     = 4'h6
  } op_kind_t;

  // request carried to the memory arrays
  typedef struct packed {
    logic        active;
    op_kind_t    kind;
    logic [23:0] addr;
    logic [15:0] data;
    logic [2:0]  span;
    logic        word;
    logic        with_ee;
  } nvm_op_t;

endpackage : nvm_seq_pkg

//--- logic/nvm_erase_write_sequencer.sv
// command sequencer of the nonvolatile memory controller, AHB-Lite slave
//
// Operation
// (RULE1) flash write mode accepts many stores; byte store, word store
// (RULE2) agent must erase before plain write; plain writes never erase
// (RULE3) page erase mode: each flash store erases the containing page
// (RULE4) cpu halted during every flash erase
// (RULE5) multi-page erase ignores low log2(size) page bits
// (RULE6) eeprom write: many stores, cpu halted on access while busy
// (RULE7) erase-write mode erases byte then writes stored value
// (RULE8) byte erase erases addressed byte only, reads back 0xff
// (RULE9) multi-byte erase ignores low log2(size) address bits
// (RULE10) new eeprom access while busy gets a bus wait
// (RULE11) chip erase clears flash and eeprom unless preserve fuse set
// (RULE12) locked device always erases eeprom on chip erase
// (RULE13) protection bits never block chip erase; all reads 0xff after
// (RULE14) chip erase only from programming/debug port
// (RULE15) full eeprom erase sets all bytes 0xff, halts cpu
// (RULE16) fuses untouched; enabled brownout detector held during chip erase
// (RULE17) reset aborts an ongoing write
// (RULE18) ready flag set whenever eeprom becomes ready
// (RULE19) irq while ready flag and enable set, until flag cleared
// (RULE20) sleep: controller sleeps unless eeprom busy, then clock kept
// (RULE21) ready interrupt wakes only from idle sleep
// (RULE22) protected register written only within four instructions of key
// (RULE23) command guarded by store key, mapping by io key
// (RULE24) seven-bit command field decode
// (RULE25) direct switch between active commands sets collision error
// (RULE26) software checks busy flags before writing a command
// (RULE27) store with no active command starts nothing
// (RULE28) writing one clears ready flag, zero leaves it
`timescale 1ns/1ps
module nvm_erase_write_sequencer
  import nvm_seq_pkg::*;
#(
  parameter int         PAGE_BITS = 9,
  parameter logic [7:0] KEY_PMS_V = 8'h5a,  // arbitrary unlock value
  parameter logic [7:0] KEY_IOR_V = 8'ha5   // arbitrary unlock value
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // cpu access to arrays
  input  wire logic        instr_retire,
  input  wire logic        store_valid,
  input  wire logic        load_valid,
  input  wire logic        store_ee,
  input  wire logic        store_word,
  input  wire logic [23:0] store_addr,
  input  wire logic [15:0] store_data,
  output logic             access_wait,
  output logic             cpu_halt,
  // programming/debug port and device state
  input  wire logic        pdp_cmd_valid,
  input  wire logic [6:0]  pdp_cmd,
  input  wire logic        eeprom_preserve_fuse,
  input  wire logic        device_locked,
  input  wire logic        brownout_enabled,
  output logic             brownout_hold,
  // memory array
  output nvm_op_t          nvm_op,
  input  wire logic        nvm_op_done,
  // sleep and interrupt
  input  wire logic        sys_sleep,
  input  wire logic        sleep_idle,
  output logic             ctrl_sleep,
  output logic             clock_keep_on,
  output logic             irq,
  output logic             wake
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_FL   = 3'b010,
    SEQ_EE   = 3'b100
  } seq_t;

  typedef struct packed {
    seq_t        seq;
    logic [6:0]  cmd;
    logic [2:0]  err;
    logic [7:0]  map;
    logic        int_en;
    logic        rdy_flag;
    key_kind_t   key;
    logic [2:0]  key_cnt;
    nvm_op_t     op;
    logic        halt;
    logic        wt;
    logic        brownout_detector;
    logic [23:0] last_addr;
    logic [15:0] last_data;
    logic        wr_pend;
    logic [3:0]  wr_idx;
    logic [31:0] rdata;
    logic        irq;
    logic        wake;
    logic        csleep;
    logic        ckeep;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [23:0] mask_low(input logic [23:0] a,
                                           input int n);
    logic [23:0] m;
    m = '1;
    m = m << n;
    return a & m;
  endfunction : mask_low

  function automatic logic is_idle_cmd(input logic [6:0] c);
    return (c == CMD_NONE) || (c == CMD_NOP);
  endfunction : is_idle_cmd

  // (RULE24) legal codes only
  function automatic logic is_legal_cmd(input logic [6:0] c);
    return is_idle_cmd(c) || c == CMD_FL_WRITE || c == CMD_FL_PAGE ||
           (c >= CMD_FL_MP_LO && c <= CMD_FL_MP_HI) ||
           c == CMD_EE_WRITE || c == CMD_EE_ERWR || c == CMD_EE_BYTE ||
           (c >= CMD_EE_MB_LO && c <= CMD_EE_MB_HI) ||
           c == CMD_CHIP_ERASE || c == CMD_EE_FULL;
  endfunction : is_legal_cmd

  logic        addr_ok;
  logic [3:0]  a_idx;
  logic        busy;
  logic        ee_ready_ev;
  logic [2:0]  span;
  logic [6:0]  wcmd;

  assign a_idx   = haddr[5:2];
  assign addr_ok = hsel && hready && htrans == HTRANS_NSEQ;

  always_comb begin
    st_next     = st_reg;
    busy        = st_reg.seq != SEQ_IDLE;
    ee_ready_ev = 1'b0;
    span        = 3'h0;
    wcmd        = hwdata[6:0];

    // ************************************************************
    // unlock window
    // ************************************************************
    // (RULE22) window counts down on retired instructions
    if (st_reg.key_cnt != 3'h0 && instr_retire) begin
      st_next.key_cnt = st_reg.key_cnt - 3'h1;
      if (st_reg.key_cnt == 3'h1) begin
        st_next.key = KEY_NONE;
      end
    end

    // ************************************************************
    // ahb write data phase
    // ************************************************************
    if (st_reg.wr_pend) begin
      unique case (st_reg.wr_idx)
        IDX_COMMAND: begin
          // (RULE23) command needs the store key
          if (st_reg.key == KEY_PMS && st_reg.key_cnt != 3'h0 &&
              is_legal_cmd(wcmd)) begin
            st_next.key     = KEY_NONE;
            st_next.key_cnt = 3'h0;
            // (RULE25) direct active-to-active switch
            if (!is_idle_cmd(st_reg.cmd) && !is_idle_cmd(wcmd) &&
                wcmd != st_reg.cmd) begin
              st_next.err = ERR_COLLIDE;
            end else begin
              st_next.err = ERR_NONE;
            end
            // (RULE14) chip erase refused from the cpu bus
            if (wcmd != CMD_CHIP_ERASE) begin
              st_next.cmd = wcmd;
            end
            // (RULE15) full eeprom erase starts on the write
            if (wcmd == CMD_EE_FULL && !busy) begin
              st_next.seq        = SEQ_EE;
              st_next.op.active  = 1'b1;
              st_next.op.kind    = OP_EE_ALL;
              st_next.op.data    = ERASED_DATA;
              st_next.op.with_ee = 1'b1;
              st_next.halt       = 1'b1;
            end
          end
        end
        IDX_MAPPING: begin
          // flash window field is unprotected unless locked
          if (!st_reg.map[MAP_LOCK_BIT]) begin
            st_next.map = (st_next.map & ~MAP_FLMAP_M) |
                          (hwdata[7:0] & MAP_FLMAP_M);
          end
          // (RULE23) protection bits need the io key, set-only
          if (st_reg.key == KEY_IOR && st_reg.key_cnt != 3'h0) begin
            st_next.map     = st_next.map | (hwdata[7:0] & MAP_PROT_M);
            st_next.key     = KEY_NONE;
            st_next.key_cnt = 3'h0;
          end
        end
        IDX_INT_EN: begin
          st_next.int_en = hwdata[0];
        end
        IDX_INT_FLAG: begin
          // (RULE28) write one clears
          if (hwdata[0]) begin
            st_next.rdy_flag = 1'b0;
          end
        end
        IDX_UNLOCK: begin
          // (RULE22) key opens a four-instruction window
          if (hwdata[7:0] == KEY_PMS_V) begin
            st_next.key     = KEY_PMS;
            st_next.key_cnt = UNLOCK_INSTR;
          end else if (hwdata[7:0] == KEY_IOR_V) begin
            st_next.key     = KEY_IOR;
            st_next.key_cnt = UNLOCK_INSTR;
          end
        end
        default: begin
        end
      endcase
    end

    // ************************************************************
    // chip erase from the debug port
    // ************************************************************
    // (RULE14) only this port can start it
    if (pdp_cmd_valid && pdp_cmd == CMD_CHIP_ERASE && !busy) begin
      st_next.seq        = SEQ_FL;
      st_next.op.active  = 1'b1;
      st_next.op.kind    = OP_CHIP;
      // (RULE13) protection bits ignored
      st_next.op.data    = ERASED_DATA;
      st_next.halt       = 1'b1;
      // (RULE11) (RULE12) eeprom kept only when unlocked and fused
      st_next.op.with_ee = device_locked || !eeprom_preserve_fuse;
      // (RULE16) brownout level held through the erase
      st_next.brownout_detector        = brownout_enabled;
    end

    // ************************************************************
    // stores to the arrays
    // ************************************************************
    // (RULE10) taken only when no wait is shown
    if (store_valid && !st_reg.wt && !busy) begin
      st_next.last_addr = store_addr;
      st_next.last_data = store_data;
      st_next.op.addr   = store_addr;
      st_next.op.data   = store_data;
      st_next.op.word   = store_word;
      st_next.op.span   = 3'h0;
      if (!store_ee) begin
        // (RULE1) byte or word write
        if (st_reg.cmd == CMD_FL_WRITE) begin
          st_next.seq       = SEQ_FL;
          st_next.op.active = 1'b1;
          st_next.op.kind   = OP_FL_WRITE;
        end else if (st_reg.cmd == CMD_FL_PAGE ||
                     (st_reg.cmd >= CMD_FL_MP_LO &&
                      st_reg.cmd <= CMD_FL_MP_HI)) begin
          // (RULE3) (RULE5) page or aligned page group
          if (st_reg.cmd != CMD_FL_PAGE) begin
            span = st_reg.cmd[2:0] - CMD_FL_PAGE[2:0];
          end
          st_next.seq       = SEQ_FL;
          st_next.op.active = 1'b1;
          st_next.op.kind   = OP_FL_ERASE;
          st_next.op.span   = span;
          st_next.op.addr   = mask_low(store_addr,
                                       PAGE_BITS + int'(span));
          st_next.op.data   = ERASED_DATA;
          // (RULE4) halt for flash erase
          st_next.halt      = 1'b1;
        end
      end else begin
        if (st_reg.cmd == CMD_EE_WRITE || st_reg.cmd == CMD_EE_ERWR) begin
          // (RULE6) (RULE7) one byte, cpu keeps running
          st_next.seq       = SEQ_EE;
          st_next.op.active = 1'b1;
          st_next.op.word   = 1'b0;
          st_next.op.kind   = (st_reg.cmd == CMD_EE_ERWR) ? OP_EE_ERWR
                                                          : OP_EE_WRITE;
        end else if (st_reg.cmd == CMD_EE_BYTE ||
                     (st_reg.cmd >= CMD_EE_MB_LO &&
                      st_reg.cmd <= CMD_EE_MB_HI)) begin
          // (RULE8) (RULE9) byte or aligned group, data forced erased
          if (st_reg.cmd != CMD_EE_BYTE) begin
            span = st_reg.cmd[2:0] - CMD_EE_BYTE[2:0];
          end
          st_next.seq       = SEQ_EE;
          st_next.op.active = 1'b1;
          st_next.op.word   = 1'b0;
          st_next.op.kind   = OP_EE_ERASE;
          st_next.op.span   = span;
          st_next.op.addr   = mask_low(store_addr, int'(span));
          st_next.op.data   = ERASED_DATA;
        end
        // (RULE27) any other command starts nothing
      end
    end

    // ************************************************************
    // completion
    // ************************************************************
    if (busy && st_reg.op.active && nvm_op_done) begin
      st_next.seq       = SEQ_IDLE;
      st_next.op.active = 1'b0;
      st_next.halt      = 1'b0;
      st_next.brownout_detector       = 1'b0;
      ee_ready_ev = (st_reg.seq == SEQ_EE) || st_reg.op.with_ee;
    end
    // (RULE18) set wins over a same-cycle clear
    if (ee_ready_ev) begin
      st_next.rdy_flag = 1'b1;
    end

    // (RULE6) (RULE10) wait any array access while an op runs
    st_next.wt = st_next.seq != SEQ_IDLE;

    // ************************************************************
    // outputs, sleep, interrupt
    // ************************************************************
    // (RULE19) level until flag cleared
    st_next.irq    = st_next.rdy_flag && st_next.int_en;
    // (RULE21) wake from idle sleep only
    st_next.wake   = st_next.irq && sys_sleep && sleep_idle;
    // (RULE20) clock kept while eeprom op pending
    st_next.ckeep  = sys_sleep && st_next.seq == SEQ_EE;
    st_next.csleep = sys_sleep && st_next.seq != SEQ_EE;

    // ************************************************************
    // ahb address phase
    // ************************************************************
    st_next.wr_pend = addr_ok && hwrite;
    st_next.wr_idx  = a_idx;
    if (addr_ok && !hwrite) begin
      unique case (a_idx)
        IDX_COMMAND:  st_next.rdata = {25'h0, st_reg.cmd};
        IDX_MAPPING:  st_next.rdata = {24'h0, st_reg.map};
        IDX_STATUS:   st_next.rdata = {25'h0, st_reg.err, 2'h0,
                                       st_reg.seq == SEQ_EE,
                                       st_reg.seq == SEQ_FL};
        IDX_INT_EN:   st_next.rdata = {31'h0, st_reg.int_en};
        IDX_INT_FLAG: st_next.rdata = {31'h0, st_reg.rdy_flag};
        IDX_DATA:     st_next.rdata = {16'h0, st_reg.last_data};
        IDX_ADDR:     st_next.rdata = {8'h0, st_reg.last_addr};
        default:      st_next.rdata = 32'h0;
      endcase
    end
  end

  // (RULE17) reset drops the active request, aborting the array
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg     <= '0;
      st_reg.seq <= SEQ_IDLE;
      st_reg.map <= MAP_RESET;
      st_reg.key <= KEY_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  logic ready_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
    end
  end

  assign hreadyout     = ready_reg;
  assign hresp         = 1'b0;
  assign hrdata        = st_reg.rdata;
  assign access_wait   = st_reg.wt;
  assign cpu_halt      = st_reg.halt;
  assign brownout_hold = st_reg.brownout_detector;
  assign nvm_op        = st_reg.op;
  assign irq           = st_reg.irq;
  assign wake          = st_reg.wake;
  assign ctrl_sleep    = st_reg.csleep;
  assign clock_keep_on = st_reg.ckeep;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  halt_on_erase_a: assert property ( // (RULE4)
    nvm_op.active && nvm_op.kind == OP_FL_ERASE |-> cpu_halt)
    else $error("flash erase without cpu halt");
  page_align_a: assert property ( // (RULE5)
    $rose(nvm_op.active) && nvm_op.kind == OP_FL_ERASE |->
    (nvm_op.addr & ~mask_low(24'hffffff, PAGE_BITS + int'(nvm_op.span)))
    == 24'h0)
    else $error("multi-page erase address not aligned");
  ee_erase_data_a: assert property ( // (RULE8)
    $rose(nvm_op.active) && nvm_op.kind == OP_EE_ERASE |->
    nvm_op.data == ERASED_DATA)
    else $error("eeprom erase data not erased value");
  bus_wait_a: assert property ( // (RULE10)
    nvm_op.active |-> access_wait)
    else $error("no bus wait while op runs");
  chip_ee_a: assert property ( // (RULE12)
    pdp_cmd_valid && pdp_cmd == CMD_CHIP_ERASE && !nvm_op.active &&
    device_locked |=> nvm_op.with_ee)
    else $error("locked chip erase kept eeprom");
  no_cpu_chip_a: assert property ( // (RULE14)
    !pdp_cmd_valid && !nvm_op.active |=> nvm_op.kind != OP_CHIP ||
    !nvm_op.active)
    else $error("chip erase started without debug port");
  ready_set_a: assert property ( // (RULE18)
    nvm_op.active && nvm_op.kind == OP_EE_WRITE && nvm_op_done |=>
    st_reg.rdy_flag)
    else $error("ready flag not set at eeprom done");
  irq_level_a: assert property ( // (RULE19)
    st_reg.rdy_flag && st_reg.int_en && !st_reg.wr_pend |=> irq)
    else $error("irq missing with flag and enable");
  wake_idle_a: assert property ( // (RULE21)
    wake |-> $past(sleep_idle))
    else $error("wake outside idle sleep");
  key_window_a: assert property ( // (RULE22)
    st_reg.wr_pend && st_reg.wr_idx == IDX_COMMAND &&
    st_reg.key_cnt == 3'h0 |=> $stable(st_reg.cmd))
    else $error("command changed without unlock");
  collide_a: assert property ( // (RULE25)
    st_reg.wr_pend && st_reg.wr_idx == IDX_COMMAND && st_reg.key == KEY_PMS
    && st_reg.key_cnt != 3'h0 && is_legal_cmd(hwdata[6:0]) &&
    !is_idle_cmd(st_reg.cmd) && !is_idle_cmd(hwdata[6:0]) &&
    hwdata[6:0] != st_reg.cmd |=> st_reg.err == ERR_COLLIDE)
    else $error("collision code not set");

  chip_erase_c: cover property (
    $rose(nvm_op.active) && nvm_op.kind == OP_CHIP);
  ee_write_c: cover property (
    $rose(nvm_op.active) && nvm_op.kind == OP_EE_WRITE);
  fl_mp_erase_c: cover property (
    $rose(nvm_op.active) && nvm_op.kind == OP_FL_ERASE &&
    nvm_op.span == 3'h5);

endmodule : nvm_erase_write_sequencer

//--- verif/nvm_array_model.sv
// memory array stand-in: ends each request after a settable delay
`timescale 1ns/1ps
module nvm_array_model
  import nvm_seq_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // request and answer
  input  wire nvm_op_t    nvm_op,
  input  wire logic [5:0] dly,
  output logic            nvm_op_done
);
  logic [5:0] cnt;

  // one done pulse per request, dly+1 cycles after it shows; large is slow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt         <= 6'h0;
      nvm_op_done <= 1'b0;
    end else begin
      nvm_op_done <= 1'b0;
      cnt         <= 6'h0;
      if (nvm_op.active && !nvm_op_done) begin
        cnt         <= cnt + 6'h1;
        nvm_op_done <= (cnt == dly);
      end
    end
  end
endmodule : nvm_array_model

//--- verif/testbench.sv
// self-checking bench of the nonvolatile erase/write sequencer
`timescale 1ns/1ps
module testbench;
  import nvm_seq_pkg::*;
  localparam int         PB = 9;
  localparam logic [7:0] KP = 8'h5a;  // arbitrary unlock value
  localparam logic [7:0] KI = 8'ha5;  // arbitrary unlock value
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic instr_retire = 0, store_valid = 0, store_ee = 0, store_word = 0;
  logic access_wait, cpu_halt, pdp_cmd_valid = 0, fuse = 0, lock = 0;
  logic bod_hold, nvm_op_done, irq, sys_sleep = 0, ctrl_sleep, keep_on, wake;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [23:0] store_addr = 0;
  logic [15:0] store_data = 0;
  logic [6:0]  pdp_cmd = 0;
  logic [5:0]  dly = 6'h2;
  logic        sleep_idle = 1, bod_en = 0;
  nvm_op_t     op;
  int          miscompares = 0, compares = 0;

  nvm_erase_write_sequencer #(.PAGE_BITS(PB), .KEY_PMS_V(KP), .KEY_IOR_V(KI))
    i_nvm_erase_write_sequencer (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .instr_retire,
    .store_valid, .load_valid(1'b0), .store_ee, .store_word, .store_addr,
    .store_data, .access_wait, .cpu_halt, .pdp_cmd_valid, .pdp_cmd,
    .eeprom_preserve_fuse(fuse), .device_locked(lock),
    .brownout_enabled(bod_en), .brownout_hold(bod_hold), .nvm_op(op),
    .nvm_op_done, .sys_sleep, .sleep_idle, .ctrl_sleep,
    .clock_keep_on(keep_on), .irq, .wake);
  nvm_array_model i_nvm_array_model (.hclk, .hresetn, .nvm_op(op), .dly,
    .nvm_op_done);

  always #10 hclk = ~hclk;

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task bus(input logic w, input logic [3:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {26'h0, i, 2'b00};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task rchk(input logic [3:0] i, input logic [31:0] e, input string n);
    bus(1'b0, i, 32'h0);
    chk(n, e, rd);
  endtask : rchk

  // passes through no-operation first, so no collision is raised
  task cmd(input logic [6:0] c);
    wait_idle;
    bus(1'b1, IDX_UNLOCK, {24'h0, KP});
    bus(1'b1, IDX_COMMAND, {25'h0, CMD_NOP});
    bus(1'b1, IDX_UNLOCK, {24'h0, KP});
    bus(1'b1, IDX_COMMAND, {25'h0, c});
  endtask : cmd

  task wait_idle;
    while (access_wait !== 1'b0) @(posedge hclk) #1;
  endtask : wait_idle

  task store(input logic e, w, input logic [23:0] a, input logic [15:0] d);
    @(posedge hclk);
    store_ee    <= e;
    store_word  <= w;
    store_addr  <= a;
    store_data  <= d;
    store_valid <= 1'b1;
    do @(posedge hclk); while (access_wait !== 1'b0);
    store_valid <= 1'b0;
    #1;
  endtask : store

  task report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(IDX_MAPPING, 32'h30, "mapping");
    rchk(4'hf, 32'h0, "unmapped");
    bus(1'b1, IDX_COMMAND, 32'h12);
    rchk(IDX_COMMAND, 32'h0, "no key");
    bus(1'b1, IDX_UNLOCK, {24'h0, KI});
    bus(1'b1, IDX_COMMAND, 32'h12);
    rchk(IDX_COMMAND, 32'h0, "wrong key");
    bus(1'b1, IDX_MAPPING, 32'h31);
    rchk(IDX_MAPPING, 32'h31, "io key");
    bus(1'b1, IDX_MAPPING, 32'h32);
    rchk(IDX_MAPPING, 32'h31, "mapping no key");
    bus(1'b1, IDX_UNLOCK, {24'h0, KP});
    repeat (4) begin
      @(posedge hclk) instr_retire <= 1'b1;
      @(posedge hclk) instr_retire <= 1'b0;
    end
    bus(1'b1, IDX_COMMAND, 32'h12);
    rchk(IDX_COMMAND, 32'h0, "late key");
    store(1'b1, 1'b0, 24'h10, 16'h5a);
    chk("idle store", 32'h0, {31'h0, op.active});
    cmd(CMD_FL_PAGE);
    store(1'b0, 1'b0, 24'h100, 16'h0);
    cmd(CMD_EE_MB_HI);
    store(1'b1, 1'b0, 24'h0, 16'h0);
    cmd(CMD_FL_WRITE);
    rchk(IDX_COMMAND, 32'h2, "command");
    for (int k = 0; k < 2; k++) begin
      store(1'b0, k[0], 24'h100, 16'h1234);
      chk("flash write", {k[0], OP_FL_WRITE, 16'h1234, 1'b0},
          {op.word, op.kind, op.data, cpu_halt});
      wait_idle;
    end
    bus(1'b1, IDX_INT_EN, 32'h1);
    cmd(CMD_EE_WRITE);
    store(1'b1, 1'b0, 24'h10, 16'h5a);
    chk("ee write", {OP_EE_WRITE, 16'h5a}, {op.kind, op.data});
    wait_idle;
    rchk(IDX_INT_FLAG, 32'h1, "ready flag");
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, IDX_INT_FLAG, 32'h0);
    rchk(IDX_INT_FLAG, 32'h1, "flag kept");
    bus(1'b1, IDX_INT_FLAG, 32'h1);
    rchk(IDX_INT_FLAG, 32'h0, "flag cleared");
    chk("irq off", 32'h0, {31'h0, irq});
    dly       <= 6'h14;
    sys_sleep <= 1'b1;
    store(1'b1, 1'b0, 24'h11, 16'h22);
    @(posedge hclk) #1;
    chk("busy sleep", 32'h3, {30'h0, access_wait, keep_on});
    store(1'b1, 1'b0, 24'h12, 16'h33);
    chk("waited store", {8'h0, 24'h12}, {8'h0, op.addr});
    wait_idle;
    @(posedge hclk) #1;
    chk("sleep wake", 32'h3, {30'h0, ctrl_sleep, wake});
    @(posedge hclk) sleep_idle <= 1'b0;
    @(posedge hclk) #1;
    chk("deep wake", 32'h0, {30'h0, wake, hresp});
    sys_sleep <= 1'b0;
    dly       <= 6'h0;
    for (int s = 0; s < 6; s++) begin
      cmd(CMD_FL_PAGE + 7'(s));
      store(1'b0, 1'b0, 24'hffffff, 16'h0);
      chk("flash erase", {OP_FL_ERASE, 1'b1, 24'hffffff << (PB + s)},
          {op.kind, cpu_halt, op.addr});
      wait_idle;
      cmd(CMD_EE_BYTE + 7'(s));
      store(1'b1, 1'b0, 24'h1ff, 16'h0);
      chk("ee erase", {OP_EE_ERASE, ERASED_DATA}, {op.kind, op.data});
      chk("ee group", 24'h1ff & (24'hffffff << s), op.addr);
      wait_idle;
    end
    cmd(CMD_EE_ERWR);
    store(1'b1, 1'b0, 24'h5, 16'h77);
    chk("erase write", {OP_EE_ERWR, 16'h77}, {op.kind, op.data});
    wait_idle;
    bus(1'b1, IDX_UNLOCK, {24'h0, KP});
    bus(1'b1, IDX_COMMAND, {25'h0, CMD_EE_WRITE});
    rchk(IDX_STATUS, {25'h0, ERR_COLLIDE, 4'h0}, "collision");
    cmd(CMD_EE_FULL);
    for (int k = 0; k < 8 && op.active !== 1'b1; k++) @(posedge hclk) #1;
    chk("ee full", {OP_EE_ALL, 1'b1}, {op.kind, cpu_halt});
    wait_idle;
    cmd(CMD_CHIP_ERASE);
    repeat (8) @(posedge hclk);
    chk("cpu chip erase", 32'h0, {31'h0, op.active});
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk);
      fuse          <= (k != 1);
      lock          <= (k == 2);
      bod_en        <= (k != 1);
      pdp_cmd       <= CMD_CHIP_ERASE;
      pdp_cmd_valid <= 1'b1;
      @(posedge hclk);
      pdp_cmd_valid <= 1'b0;
      #1;
      chk("chip erase",
          {OP_CHIP, k != 0, 1'b1, k != 1, ERASED_DATA},
          {op.kind, op.with_ee, cpu_halt, bod_hold, op.data});
      wait_idle;
    end
    dly <= 6'h14;
    cmd(CMD_EE_WRITE);
    store(1'b1, 1'b0, 24'h3, 16'h1);
    hresetn <= 1'b0;
    #1;
    chk("reset abort", 32'h0, {30'h0, op.active, access_wait});
    @(posedge hclk) hresetn <= 1'b1;
    report_and_stop;
  end
endmodule : testbench
